// ---- fmr_core.sv ----
`timescale 1ns/1ns
`default_nettype none

module fmr_core #(
   parameter int MOD_W = 12
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pfd_ref_pin,
   input wire logic latch_strobe,
   input wire logic [fmr_pkg::LATCH_W-1:0] latch_data,
   output logic signed [3:0] sdm_code,
   output logic sdm_valid,
   output logic dither_en,
   output logic [3:0] cp_current,
   output logic boost_switch_closed,
   output logic sync_pulse,
   output logic resync_pulse,
   output logic [MOD_W-1:0] fractional_modulus,
   output logic dither_mod_low
);
   import fmr_pkg::*;

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic pfd_meta_reg, pfd_sync_reg, pfd_last_reg;
   logic stb_meta_reg, stb_sync_reg, stb_last_reg;
   logic [LATCH_W-1:0] data_meta_reg, data_sync_reg;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pfd_meta_reg <= 1'b0;
         pfd_sync_reg <= 1'b0;
         pfd_last_reg <= 1'b0;
         stb_meta_reg <= 1'b0;
         stb_sync_reg <= 1'b0;
         stb_last_reg <= 1'b0;
         data_meta_reg <= '0;
         data_sync_reg <= '0;
      end else begin
         pfd_meta_reg <= pfd_ref_pin;
         pfd_sync_reg <= pfd_meta_reg;
         pfd_last_reg <= pfd_sync_reg;
         stb_meta_reg <= latch_strobe;
         stb_sync_reg <= stb_meta_reg;
         stb_last_reg <= stb_sync_reg;
         data_meta_reg <= latch_data;
         data_sync_reg <= data_meta_reg;
      end
   end

   wire ref_tick = pfd_sync_reg & ~pfd_last_reg;
   wire strobe_rise = stb_sync_reg & ~stb_last_reg;

   // ****************************************
   // Latch decode
   // ****************************************
   wire [1:0] wr_addr = data_sync_reg[ADDR_MSB:ADDR_LSB];
   wire wr_n = strobe_rise && (wr_addr == ADDR_N_DIV);
   wire wr_r = strobe_rise && (wr_addr == ADDR_REF_DIV);
   wire wr_c = strobe_rise && (wr_addr == ADDR_CONTROL);
   wire wr_ns = strobe_rise && (wr_addr == ADDR_NOISE);
   wire [MOD_W-1:0] mod_field = data_sync_reg[MOD_MSB:MOD_LSB];
   wire load_sel = data_sync_reg[LOAD_SEL_BIT];
   wire mod_ok = (mod_field >= MOD_MIN);
   wire wr_delay = wr_r && load_sel;
   wire wr_mod = wr_r && !load_sel && mod_ok;

   logic [MOD_W-1:0] frac_reg, mod_reg, delay_reg;
   logic boost_reg;
   logic [3:0] rcount_reg;
   logic [2:0] mon_reg;
   logic [1:0] nmode_reg;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         frac_reg <= '0;
         boost_reg <= 1'b0;
         mod_reg <= MOD_RST;
         delay_reg <= '0;
         rcount_reg <= 4'h0;
         mon_reg <= 3'h0;
         nmode_reg <= NMODE_LOWEST_NOISE;
      end else begin
         if (wr_n) begin
            frac_reg <= data_sync_reg[FRAC_MSB:FRAC_LSB];
            boost_reg <= data_sync_reg[BOOST_BIT];
         end
         if (wr_mod) begin
            mod_reg <= mod_field;
         end
         if (wr_delay) begin
            delay_reg <= mod_field;
         end
         if (wr_c) begin
            rcount_reg <= data_sync_reg[RCNT_MSB:RCNT_LSB];
            mon_reg <= data_sync_reg[MON_MSB:MON_LSB];
         end
         if (wr_ns) begin
            nmode_reg <= data_sync_reg[NMODE_MSB:NMODE_LSB];
         end
      end
   end

   // ****************************************
   // Third-order interpolator
   // ****************************************
   logic [MOD_W-1:0] acc1_reg, acc2_reg, acc3_reg;
   logic c2d_reg, c3d_reg, c3dd_reg;
   logic [20:0] lfsr_reg;
   logic signed [3:0] code_reg;
   logic valid_reg;

   function automatic logic [MOD_W:0] mod_add(input logic [MOD_W-1:0] a,
         input logic [MOD_W-1:0] b, input logic [MOD_W-1:0] m);
      logic [MOD_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, m}) begin
         mod_add = {1'b1, MOD_W'(s - {1'b0, m})};
      end else begin
         mod_add = s;
      end
   endfunction

   wire dith = (nmode_reg == NMODE_LOW_SPUR);
   wire [MOD_W-1:0] frac_eff = (frac_reg >= mod_reg) ? MOD_W'(mod_reg - 1'b1) : frac_reg;
   wire [MOD_W-1:0] in1 = frac_eff + {{(MOD_W-1){1'b0}}, dith & lfsr_reg[0]};
   wire [MOD_W:0] s1 = mod_add(acc1_reg, in1, mod_reg);
   wire [MOD_W:0] s2 = mod_add(acc2_reg, s1[MOD_W-1:0], mod_reg);
   wire [MOD_W:0] s3 = mod_add(acc3_reg, s2[MOD_W-1:0], mod_reg);
   wire c1 = s1[MOD_W];
   wire c2 = s2[MOD_W];
   wire c3 = s3[MOD_W];
   wire signed [3:0] code_next = $signed({3'h0, c1}) + $signed({3'h0, c2})
      - $signed({3'h0, c2d_reg}) + $signed({3'h0, c3})
      - $signed({2'h0, c3d_reg, 1'b0}) + $signed({3'h0, c3dd_reg});
   wire [20:0] lfsr_next = {lfsr_reg[19:0], lfsr_reg[20] ^ lfsr_reg[18]};
   // restart on channel, modulus or noise-mode load
   wire sdm_restart = wr_n || wr_mod || wr_ns;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         acc1_reg <= '0;
         acc2_reg <= '0;
         acc3_reg <= '0;
         c2d_reg <= 1'b0;
         c3d_reg <= 1'b0;
         c3dd_reg <= 1'b0;
         lfsr_reg <= LFSR_SEED;
         code_reg <= 4'sh0;
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= ref_tick && !sdm_restart;
         if (sdm_restart) begin
            acc1_reg <= '0;
            acc2_reg <= '0;
            acc3_reg <= '0;
            c2d_reg <= 1'b0;
            c3d_reg <= 1'b0;
            c3dd_reg <= 1'b0;
            lfsr_reg <= LFSR_SEED;
            code_reg <= 4'sh0;
         end else if (ref_tick) begin
            acc1_reg <= s1[MOD_W-1:0];
            acc2_reg <= s2[MOD_W-1:0];
            acc3_reg <= s3[MOD_W-1:0];
            c2d_reg <= c2;
            c3d_reg <= c3;
            c3dd_reg <= c3d_reg;
            code_reg <= code_next;
            if (dith) begin
               lfsr_reg <= lfsr_next;
            end
         end
      end
   end

   // ****************************************
   // Fastlock pump and switch
   // ****************************************
   logic [3:0] cp_reg;
   logic sw_reg;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cp_reg <= CP_MIN;
         sw_reg <= 1'b0;
      end else begin
         cp_reg <= boost_reg ? CP_MAX : CP_MIN;
         sw_reg <= boost_reg && (mon_reg == MON_BOOST_SW);
      end
   end

   // ****************************************
   // Realign timer
   // ****************************************
   logic [15:0] timer_reg;
   logic sync_reg, resync_reg;
   fmr_rsync_t rs_reg, rs_next;

   wire [15:0] interval = 16'(rcount_reg) * 16'(delay_reg);
   wire rs_enable = (rcount_reg != 4'h0) && (delay_reg != '0);
   wire [15:0] timer_inc = timer_reg + 16'h0001;
   wire sync_hit = rs_enable && ref_tick && (timer_inc >= interval);

   always_comb begin
      rs_next = rs_reg;
      case (rs_reg)
         RS_IDLE: rs_next = RS_IDLE;
         RS_WAIT1: if (sync_hit) rs_next = RS_WAIT2;
         RS_WAIT2: if (sync_hit) rs_next = RS_IDLE;
         default: rs_next = RS_IDLE;
      endcase
      if (wr_n) begin
         rs_next = RS_WAIT1;
      end
      if (!rs_enable) begin
         rs_next = RS_IDLE;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         timer_reg <= 16'h0000;
         sync_reg <= 1'b0;
         resync_reg <= 1'b0;
         rs_reg <= RS_IDLE;
      end else begin
         sync_reg <= sync_hit;
         resync_reg <= sync_hit && (rs_reg == RS_WAIT2) && !wr_n;
         rs_reg <= rs_next;
         if (!rs_enable || sync_hit) begin
            timer_reg <= 16'h0000;
         end else if (ref_tick) begin
            timer_reg <= timer_inc;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign sdm_code = code_reg;
   assign sdm_valid = valid_reg;
   assign dither_en = dith;
   assign cp_current = cp_reg;
   assign boost_switch_closed = sw_reg;
   assign sync_pulse = sync_reg;
   assign resync_pulse = resync_reg;
   assign fractional_modulus = mod_reg;
   assign dither_mod_low = dith && (mod_reg < DITHER_MOD_MIN);

   // ****************************************
   // Assertions
   // ****************************************
   AST_MOD_RANGE: assert property (@(posedge sys_clk) disable iff (reset)
      mod_reg >= MOD_MIN)
      else $error("modulus below two");

   AST_STEP_PER_REF: assert property (@(posedge sys_clk) disable iff (reset)
      (ref_tick && !sdm_restart) |=> sdm_valid ##1 !sdm_valid)
      else $error("interpolator step not one per reference edge");

   AST_ZERO_FRAC: assert property (@(posedge sys_clk) disable iff (reset)
      (!dith && frac_reg == '0 && $past(frac_reg) == '0 && sdm_valid) |-> sdm_code == 4'sh0)
      else $error("zero fraction gave nonzero code");

   AST_DITHER_MOVES: assert property (@(posedge sys_clk) disable iff (reset)
      (dith && ref_tick && !sdm_restart) |=> lfsr_reg != $past(lfsr_reg))
      else $error("dither sequence stalled");

   AST_BOOST_MAX: assert property (@(posedge sys_clk) disable iff (reset)
      boost_reg [*2] |-> cp_current == CP_MAX)
      else $error("boost without maximum current");

   AST_BOOST_OFF: assert property (@(posedge sys_clk) disable iff (reset)
      $fell(boost_reg) |=> (cp_current == CP_MIN && !boost_switch_closed))
      else $error("boost clear left pump high or switch closed");

   AST_REALIGN_OFF: assert property (@(posedge sys_clk) disable iff (reset)
      (rcount_reg == 4'h0 && $past(rcount_reg) == 4'h0) |-> !sync_pulse)
      else $error("sync pulse with realignment disabled");

   AST_DELAY_LOAD: assert property (@(posedge sys_clk) disable iff (reset)
      wr_delay |=> (delay_reg == $past(mod_field) && $stable(mod_reg)))
      else $error("load-select write misrouted");

   AST_TIMER_RELOAD: assert property (@(posedge sys_clk) disable iff (reset)
      sync_pulse |-> (timer_reg == 16'h0000 && $past(timer_inc) >= $past(interval)))
      else $error("sync pulse without interval");

   AST_SECOND_SYNC: assert property (@(posedge sys_clk) disable iff (reset)
      resync_pulse |-> (sync_pulse && $past(rs_reg) == RS_WAIT2))
      else $error("realign not on second sync");

   AST_CHANNEL_REPEAT: assert property (@(posedge sys_clk) disable iff (reset)
      wr_n |=> (acc1_reg == '0 && acc3_reg == '0 && lfsr_reg == LFSR_SEED))
      else $error("interpolator not restarted on load");

endmodule

`default_nettype wire

// ---- fmr_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module fmr_host_model (
   input wire logic sys_clk,
   output logic latch_strobe,
   output logic [fmr_pkg::LATCH_W-1:0] latch_data
);
   import fmr_pkg::*;

   initial begin
      latch_strobe = 1'b0;
      latch_data = 24'h000000;
   end

   // ****************************************
   // Latch write
   // ****************************************
   task automatic write(input logic [1:0] addr, input logic [23:0] word);
      @(posedge sys_clk);
      #1 latch_data = {word[23:2], addr};
      // Data settles well before the strobe edge
      repeat (5) @(posedge sys_clk);
      #1 latch_strobe = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 latch_strobe = 1'b0;
      // Hold over, word no longer valid
      latch_data = ~latch_data;
      repeat (4) @(posedge sys_clk);
   endtask

endmodule

`default_nettype wire

// ---- fmr_pkg.sv ----
// Contract
// - Modulus accepted from 2 to 4095
// - Interpolator steps once per reference cycle
// - Undithered repeat length follows modulus divisibility
// - Dithered repeat length about two to twenty-one
// - Boost bit forces maximum pump current
// - Boost cleared: lowest current, switch open
// - Sync spacing is count times delay periods
// - Realign count in control bits 15..12
// - Zero realign count disables realignment
// - Load-select high stores delay, not modulus
// - Realign on second sync after strobe
// - Same channel gives same interpolator sequence
// - Only low-spur mode enables dither
//
`default_nettype none

package fmr_pkg;

   // ****************************************
   // Latch word layout
   // ****************************************
   localparam int LATCH_W = 24;
   localparam int ADDR_MSB = 1;
   localparam int ADDR_LSB = 0;
   localparam logic [1:0] ADDR_N_DIV = 2'h0;
   localparam logic [1:0] ADDR_REF_DIV = 2'h1;
   localparam logic [1:0] ADDR_CONTROL = 2'h2;
   localparam logic [1:0] ADDR_NOISE = 2'h3;

   localparam int FRAC_MSB = 14;
   localparam int FRAC_LSB = 3;
   localparam int BOOST_BIT = 23;
   localparam int MOD_MSB = 13;
   localparam int MOD_LSB = 2;
   localparam int LOAD_SEL_BIT = 23;
   localparam int RCNT_MSB = 15;
   localparam int RCNT_LSB = 12;
   localparam int MON_MSB = 22;
   localparam int MON_LSB = 20;
   localparam int NMODE_MSB = 6;
   localparam int NMODE_LSB = 5;

   // ****************************************
   // Codes and reset values
   // ****************************************
   localparam logic [2:0] MON_BOOST_SW = 3'h5;
   localparam logic [1:0] NMODE_LOWEST_NOISE = 2'h0;
   localparam logic [1:0] NMODE_LOW_NOISE_SPUR = 2'h1;
   localparam logic [1:0] NMODE_LOW_SPUR = 2'h2;
   localparam logic [11:0] MOD_MIN = 12'h002;
   localparam logic [11:0] MOD_RST = 12'h002;
   localparam logic [11:0] DITHER_MOD_MIN = 12'h032;
   localparam logic [3:0] CP_MAX = 4'hf;
   localparam logic [3:0] CP_MIN = 4'h0;
   localparam logic [20:0] LFSR_SEED = 21'h000001;

   typedef enum logic [1:0] {RS_IDLE, RS_WAIT1, RS_WAIT2} fmr_rsync_t;

endpackage

`default_nettype wire

// ---- frac_modulator_fastlock_resync_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module frac_modulator_fastlock_resync_test;
   import fmr_pkg::*;

   logic sys_clk, reset, pfd_ref_pin, latch_strobe, sdm_valid, dither_en;
   logic boost_switch_closed, sync_pulse, resync_pulse, dither_mod_low;
   logic [23:0] latch_data;
   logic signed [3:0] sdm_code;
   logic [3:0] cp_current;
   logic [11:0] fractional_modulus;
   logic signed [3:0] seq [20];
   logic signed [3:0] first [20];
   int n_mismatch = 0, checks_done = 0, n_sync = 0, at_resync = 0, n_valid = 0;
   int v_per = 0, n_seq = 0;
   time t_load = 0, t_sync = 0, dt = 0;

   fmr_core i_fmr_core (.sys_clk(sys_clk), .reset(reset), .pfd_ref_pin(pfd_ref_pin),
      .latch_strobe(latch_strobe), .latch_data(latch_data), .sdm_code(sdm_code),
      .sdm_valid(sdm_valid), .dither_en(dither_en), .cp_current(cp_current),
      .boost_switch_closed(boost_switch_closed), .sync_pulse(sync_pulse),
      .resync_pulse(resync_pulse), .fractional_modulus(fractional_modulus),
      .dither_mod_low(dither_mod_low));

   fmr_host_model i_fmr_host_model (.sys_clk(sys_clk), .latch_strobe(latch_strobe),
      .latch_data(latch_data));

   // ****************************************
   // Clocks
   // ****************************************
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   initial begin
      pfd_ref_pin = 1'b0;
      #21;
      forever #160 pfd_ref_pin = ~pfd_ref_pin;
   end

   // ****************************************
   // Monitors
   // ****************************************
   always @(posedge latch_strobe) begin
      n_sync = 0;
      at_resync = 0;
      n_seq = 0;
      t_load = $time;
   end

   always @(posedge sys_clk) begin
      if (sdm_valid === 1'b1) begin
         n_valid++;
         if ($time > t_load + 150 && n_seq < 20) begin
            seq[n_seq] = sdm_code;
            n_seq++;
         end
      end
      if (sync_pulse === 1'b1) begin
         n_sync++;
         dt = $time - t_sync;
         t_sync = $time;
         v_per = n_valid;
         n_valid = 0;
      end
      if (resync_pulse === 1'b1) at_resync = n_sync;
   end

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #400000;
      n_mismatch++;
      finish_test;
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      reset = 1'b1;
      repeat (16) @(posedge sys_clk);
      #1 reset = 1'b0;
      check("modulus", 16'(fractional_modulus), 16'(MOD_RST));
      check("pump", 16'(cp_current), 16'(CP_MIN));
      check("dither", 16'(dither_en), 16'h0000);
      $display("test reset done");

      i_fmr_host_model.write(ADDR_N_DIV, 24'h800000);
      check("switch", 16'(boost_switch_closed), 16'h0000);
      i_fmr_host_model.write(ADDR_CONTROL, 24'h500000);
      i_fmr_host_model.write(ADDR_N_DIV, 24'h800000);
      check("pump", 16'(cp_current), 16'(CP_MAX));
      check("switch", 16'(boost_switch_closed), 16'h0001);
      i_fmr_host_model.write(ADDR_N_DIV, 24'h000000);
      check("pump", 16'(cp_current), 16'(CP_MIN));
      check("switch", 16'(boost_switch_closed), 16'h0000);
      $display("test boost done");

      for (int m = 0; m < 4; m++) begin
         i_fmr_host_model.write(ADDR_NOISE, 24'(m) << 5);
         check("dither", 16'(dither_en), 16'(m == 2));
         check("dither low", 16'(dither_mod_low), 16'(m == 2));
      end
      i_fmr_host_model.write(ADDR_NOISE, 24'h000000);
      $display("test noise done");

      i_fmr_host_model.write(ADDR_REF_DIV, 24'h003ffc);
      check("modulus", 16'(fractional_modulus), 16'h0fff);
      i_fmr_host_model.write(ADDR_REF_DIV, 24'h000004);
      check("modulus", 16'(fractional_modulus), 16'h0fff);
      i_fmr_host_model.write(ADDR_REF_DIV, 24'h000008);
      check("modulus", 16'(fractional_modulus), 16'h0002);
      $display("test modulus done");

      // Count 2, delay 7, modulus 7
      i_fmr_host_model.write(ADDR_CONTROL, 24'h502000);
      i_fmr_host_model.write(ADDR_REF_DIV, 24'h80001c);
      check("modulus", 16'(fractional_modulus), 16'h0002);
      i_fmr_host_model.write(ADDR_REF_DIV, 24'h00001c);
      i_fmr_host_model.write(ADDR_N_DIV, 24'h000018);
      for (int i = 0; i < 400 && at_resync == 0; i++) @(posedge sys_clk);
      check("resync", 16'(at_resync), 16'h0002);
      check("interval", 16'(dt), 16'(14 * 320));
      check("steps", 16'(v_per), 16'h000e);
      repeat (60) @(posedge sys_clk);
      check("code sum", 16'(seq[0] + seq[1] + seq[2] + seq[3] + seq[4] + seq[5] + seq[6]),
         16'h0003);
      for (int i = 0; i < 13; i++) check("repeat", 16'(seq[i + 7]), 16'(seq[i]));
      first = seq;
      i_fmr_host_model.write(ADDR_N_DIV, 24'h000018);
      repeat (200) @(posedge sys_clk);
      for (int i = 0; i < 20; i++) check("same seq", 16'(seq[i]), 16'(first[i]));
      $display("test realign done");

      i_fmr_host_model.write(ADDR_CONTROL, 24'h500000);
      repeat (150) @(posedge sys_clk);
      check("sync off", 16'(n_sync), 16'h0000);
      $display("test disable done");
      finish_test;
   end

endmodule

`default_nettype wire
